// ===== shared/pie_pkg.sv
// Package for the peripheral interrupt enable bank: offsets, masks, field layouts
package pie_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] ADDR_EN1     = 4'h0;
    localparam logic [3:0] ADDR_EN2     = 4'h1;
    localparam logic [3:0] ADDR_EN3     = 4'h2;
    localparam logic [3:0] ADDR_EN4     = 4'h3;
    localparam logic [3:0] ADDR_CTRL    = 4'h4;
    localparam logic [3:0] ADDR_FLAG1   = 4'h5;
    localparam logic [3:0] ADDR_FLAG2   = 4'h6;
    localparam logic [3:0] ADDR_FLAG3   = 4'h7;
    localparam logic [3:0] ADDR_FLAG4   = 4'h8;
    localparam logic [3:0] ADDR_ISTAT   = 4'h9;
    localparam logic [3:0] ADDR_IMASK   = 4'hA;
    localparam logic [3:0] ADDR_PEND    = 4'hB;

    // Implemented bit masks per enable register
    localparam logic [7:0] MASK_EN1     = 8'hFF;
    localparam logic [7:0] MASK_EN2     = 8'hF9;
    localparam logic [7:0] MASK_EN3     = 8'h3A;
    localparam logic [7:0] MASK_EN4     = 8'h03;
    localparam logic [7:0] RESET_EN     = 8'h00;

    // Control register bit positions
    localparam int CTRL_GLOBAL_BIT      = 7;
    localparam int CTRL_GROUP_BIT       = 6;
    localparam logic [7:0] MASK_CTRL    = 8'hC0;

    // Local event status bits
    localparam int EVT_REQ_RISE         = 0;
    localparam int EVT_REQ_FALL         = 1;
    localparam logic [7:0] MASK_EVT     = 8'h03;

    // Register file: every piece of state in one struct
    typedef struct packed {
        logic [7:0] en1;
        logic [7:0] en2;
        logic [7:0] en3;
        logic [7:0] en4;
        logic       global_irq_en;
        logic       peripheral_group_irq_en;
        logic [7:0] evt_stat;
        logic [7:0] evt_mask;
        logic       core_req_q;
        logic [7:0] rdata;
    } pie_state_t;

    // Thirty-two source flags, grouped like the enable registers
    typedef struct packed {
        logic [7:0] f4;
        logic [7:0] f3;
        logic [7:0] f2;
        logic [7:0] f1;
    } pie_flags_t;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pie_req_t;
endpackage

// ===== hdl/pie_gate.sv
// Gating network: flag AND enable, OR-reduced, then group gate
`timescale 1ns/1ns
module pie_gate (
    input  wire logic [31:0] flags,
    input  wire logic [31:0] enables,
    input  wire logic        group_en,
    output logic             any_req,
    output logic             periph_req
);
    // [R11] OR over all sources of flag AND enable
    assign any_req    = |(flags & enables);
    // [R1] [R10] Group enable gate
    assign periph_req = any_req & group_en;
endmodule // pie_gate

// ===== hdl/pie_bank.sv
// Peripheral interrupt enable bank with control, flag view and event status
//
// Summary of operation
// [R1] No request without group enable set
// [R2] One enables a source, zero disables
// [R3] First register: eight sources, all writable
// [R4] Second register: bits 2 and 1 absent
// [R5] Third register: bits 5,4,3,1 only
// [R6] Fourth register: bits 1 and 0 only
// [R7] All enables clear on every reset
// [R8] Absent bits ignore writes, read zero
// [R9] Flags set regardless of any enable
// [R10] Group enable passes or blocks all
// [R11] Request is OR of flag-and-enable, gated
`timescale 1ns/1ns
module pie_bank (
    input  wire logic               mclk,
    input  wire logic               rst_b,
    input  wire pie_pkg::pie_req_t  req,
    input  wire pie_pkg::pie_flags_t src_flags,
    output logic [7:0]              rdata,
    output logic                    periph_req,
    output logic                    core_irq,
    output logic                    evt_irq
);
    pie_pkg::pie_state_t s_r;
    pie_pkg::pie_state_t s_nxt;
    logic [31:0]         en_all;
    logic                any_req;
    logic [7:0]          evt_set;

    // Mask a written byte to its implemented bits
    function automatic logic [7:0] keep_bits(input logic [7:0] d, input logic [7:0] m);
        keep_bits = d & m;
    endfunction

    // [R2] One bit enables its source
    assign en_all = {s_r.en4, s_r.en3, s_r.en2, s_r.en1};

    // [R9] Flags enter ungated by enables
    pie_gate u_gate (
        .flags      (src_flags),
        .enables    (en_all),
        .group_en   (s_r.peripheral_group_irq_en),
        .any_req    (any_req),
        .periph_req (periph_req)
    );

    // Core sees peripheral request only under global enable
    assign core_irq = periph_req & s_r.global_irq_en;
    // Events: edges of the gated request, useful for counting bursts
    assign evt_set = {6'h00, s_r.core_req_q & ~periph_req, ~s_r.core_req_q & periph_req};
    assign evt_irq = |(s_r.evt_stat & s_r.evt_mask);
    assign rdata   = s_r.rdata;

    // Next state of all registers
    always_comb begin
        s_nxt            = s_r;
        s_nxt.core_req_q = periph_req;
        s_nxt.rdata      = 8'h00;
        if (req.wr) begin
            case (req.addr)
                // [R3] First register fully writable
                pie_pkg::ADDR_EN1: s_nxt.en1 = keep_bits(req.wdata, pie_pkg::MASK_EN1);
                // [R4] [R8] Second register masked
                pie_pkg::ADDR_EN2: s_nxt.en2 = keep_bits(req.wdata, pie_pkg::MASK_EN2);
                // [R5] [R8] Third register masked
                pie_pkg::ADDR_EN3: s_nxt.en3 = keep_bits(req.wdata, pie_pkg::MASK_EN3);
                // [R6] [R8] Fourth register masked
                pie_pkg::ADDR_EN4: s_nxt.en4 = keep_bits(req.wdata, pie_pkg::MASK_EN4);
                pie_pkg::ADDR_CTRL: begin
                    s_nxt.global_irq_en           = req.wdata[pie_pkg::CTRL_GLOBAL_BIT];
                    s_nxt.peripheral_group_irq_en = req.wdata[pie_pkg::CTRL_GROUP_BIT];
                end
                pie_pkg::ADDR_ISTAT: s_nxt.evt_stat = s_r.evt_stat & ~keep_bits(req.wdata, pie_pkg::MASK_EVT);
                pie_pkg::ADDR_IMASK: s_nxt.evt_mask = keep_bits(req.wdata, pie_pkg::MASK_EVT);
                default: ;
            endcase
        end
        // New events win over a clear in the same cycle
        s_nxt.evt_stat = s_nxt.evt_stat | evt_set;
        if (req.rd) begin
            case (req.addr)
                // [R8] Absent bits read zero
                pie_pkg::ADDR_EN1:   s_nxt.rdata = s_r.en1;
                pie_pkg::ADDR_EN2:   s_nxt.rdata = keep_bits(s_r.en2, pie_pkg::MASK_EN2);
                pie_pkg::ADDR_EN3:   s_nxt.rdata = keep_bits(s_r.en3, pie_pkg::MASK_EN3);
                pie_pkg::ADDR_EN4:   s_nxt.rdata = keep_bits(s_r.en4, pie_pkg::MASK_EN4);
                pie_pkg::ADDR_CTRL:  s_nxt.rdata = {s_r.global_irq_en, s_r.peripheral_group_irq_en, 6'h00};
                pie_pkg::ADDR_FLAG1: s_nxt.rdata = src_flags.f1;
                pie_pkg::ADDR_FLAG2: s_nxt.rdata = src_flags.f2;
                pie_pkg::ADDR_FLAG3: s_nxt.rdata = src_flags.f3;
                pie_pkg::ADDR_FLAG4: s_nxt.rdata = src_flags.f4;
                pie_pkg::ADDR_ISTAT: s_nxt.rdata = s_r.evt_stat;
                pie_pkg::ADDR_IMASK: s_nxt.rdata = s_r.evt_mask;
                pie_pkg::ADDR_PEND:  s_nxt.rdata = {5'h00, core_irq, periph_req, any_req};
                default:             s_nxt.rdata = 8'h00;
            endcase
        end
    end

    // [R7] Everything clears on reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Assertions
    property p_group_block;
        @(posedge mclk) disable iff (!rst_b) !s_r.peripheral_group_irq_en |-> !periph_req;
    endproperty
    a_group_block: assert property (p_group_block) else $error("request without group enable"); // [R1]

    property p_pass;
        @(posedge mclk) disable iff (!rst_b)
            (s_r.peripheral_group_irq_en && |(src_flags & en_all)) |-> periph_req;
    endproperty
    a_pass: assert property (p_pass) else $error("enabled request blocked"); // [R10]

    // [R11] Per-register combined request
    // Written register by register, so a swapped byte in the gate wiring shows up
    property p_or;
        @(posedge mclk) disable iff (!rst_b)
            any_req == (((src_flags.f1 & s_r.en1) != 8'h00) || ((src_flags.f2 & s_r.en2) != 8'h00) ||
                        ((src_flags.f3 & s_r.en3) != 8'h00) || ((src_flags.f4 & s_r.en4) != 8'h00));
    endproperty
    a_or: assert property (p_or) else $error("combined request wrong"); // [R11]

    property p_wr1;
        @(posedge mclk) disable iff (!rst_b)
            (req.wr && req.addr == pie_pkg::ADDR_EN1) |=> s_r.en1 == $past(req.wdata);
    endproperty
    a_wr1: assert property (p_wr1) else $error("first register write lost"); // [R3]

    property p_wr2;
        @(posedge mclk) disable iff (!rst_b) (s_r.en2 & ~pie_pkg::MASK_EN2) == 8'h00;
    endproperty
    a_wr2: assert property (p_wr2) else $error("absent bit set in second register"); // [R4]

    property p_wr3;
        @(posedge mclk) disable iff (!rst_b) (s_r.en3 & ~pie_pkg::MASK_EN3) == 8'h00;
    endproperty
    a_wr3: assert property (p_wr3) else $error("absent bit set in third register"); // [R5]

    property p_wr4;
        @(posedge mclk) disable iff (!rst_b) (s_r.en4 & ~pie_pkg::MASK_EN4) == 8'h00;
    endproperty
    a_wr4: assert property (p_wr4) else $error("absent bit set in fourth register"); // [R6]

    sequence s_rd_en2;
        req.rd && req.addr == pie_pkg::ADDR_EN2;
    endsequence
    property p_rd_zero;
        @(posedge mclk) disable iff (!rst_b) s_rd_en2 |=> (rdata & ~pie_pkg::MASK_EN2) == 8'h00;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("absent bit read nonzero"); // [R8]

    property p_enable_one;
        @(posedge mclk) disable iff (!rst_b)
            (s_r.peripheral_group_irq_en && src_flags.f1[7] && s_r.en1[7]) |-> periph_req;
    endproperty
    a_enable_one: assert property (p_enable_one) else $error("enabled source not passed"); // [R2]

    property p_reset_clear;
        @(posedge mclk) $rose(rst_b) |-> (en_all == 32'h0000_0000);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("enables not clear after reset"); // [R7]

    property p_flag_view;
        @(posedge mclk) disable iff (!rst_b)
            (req.rd && req.addr == pie_pkg::ADDR_FLAG1) |=> rdata == $past(src_flags.f1);
    endproperty
    a_flag_view: assert property (p_flag_view) else $error("flag view gated"); // [R9]

    // Register-level checks on the remaining registers and on the event logic

    // [R8] Third register reads
    sequence s_rd_en3;
        req.rd && req.addr == pie_pkg::ADDR_EN3;
    endsequence
    property p_rd_zero3;
        @(posedge mclk) disable iff (!rst_b) s_rd_en3 |=> (rdata & ~pie_pkg::MASK_EN3) == 8'h00;
    endproperty
    a_rd_zero3: assert property (p_rd_zero3) else $error("absent bit read nonzero in third register"); // [R8]

    // [R8] Fourth register reads
    sequence s_rd_en4;
        req.rd && req.addr == pie_pkg::ADDR_EN4;
    endsequence
    property p_rd_zero4;
        @(posedge mclk) disable iff (!rst_b) s_rd_en4 |=> (rdata & ~pie_pkg::MASK_EN4) == 8'h00;
    endproperty
    a_rd_zero4: assert property (p_rd_zero4) else $error("absent bit read nonzero in fourth register"); // [R8]

    // Read data stand one cycle only, so a stale value never passes for a fresh answer
    property p_rd_idle;
        @(posedge mclk) disable iff (!rst_b) !req.rd |=> rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data held past one cycle");

    // [R4] Second register write lands
    property p_wr2_lands;
        @(posedge mclk) disable iff (!rst_b)
            (req.wr && req.addr == pie_pkg::ADDR_EN2) |=> s_r.en2 == ($past(req.wdata) & pie_pkg::MASK_EN2);
    endproperty
    a_wr2_lands: assert property (p_wr2_lands) else $error("second register write lost"); // [R4]

    // [R5] Third register write lands
    property p_wr3_lands;
        @(posedge mclk) disable iff (!rst_b)
            (req.wr && req.addr == pie_pkg::ADDR_EN3) |=> s_r.en3 == ($past(req.wdata) & pie_pkg::MASK_EN3);
    endproperty
    a_wr3_lands: assert property (p_wr3_lands) else $error("third register write lost"); // [R5]

    // [R6] Fourth register write lands
    property p_wr4_lands;
        @(posedge mclk) disable iff (!rst_b)
            (req.wr && req.addr == pie_pkg::ADDR_EN4) |=> s_r.en4 == ($past(req.wdata) & pie_pkg::MASK_EN4);
    endproperty
    a_wr4_lands: assert property (p_wr4_lands) else $error("fourth register write lost"); // [R6]

    // [R10] Group bit write
    property p_ctrl_wr;
        @(posedge mclk) disable iff (!rst_b)
            (req.wr && req.addr == pie_pkg::ADDR_CTRL) |=>
                s_r.peripheral_group_irq_en == $past(req.wdata[pie_pkg::CTRL_GROUP_BIT]);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("group enable write lost"); // [R10]

    // [R10] Group passes all
    property p_group_pass;
        @(posedge mclk) disable iff (!rst_b) s_r.peripheral_group_irq_en |-> periph_req == any_req;
    endproperty
    a_group_pass: assert property (p_group_pass) else $error("group enable blocks a request"); // [R10]

    // [R2] Zero disables sources
    property p_all_off;
        @(posedge mclk) disable iff (!rst_b) (en_all == 32'h0000_0000) |-> !any_req;
    endproperty
    a_all_off: assert property (p_all_off) else $error("request with every enable clear"); // [R2]

    // [R7] Control clears too
    property p_reset_ctrl;
        @(posedge mclk) $rose(rst_b) |-> !s_r.global_irq_en && !s_r.peripheral_group_irq_en;
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("control not clear after reset"); // [R7]

    // [R11] Global gate last
    property p_core_gate;
        @(posedge mclk) disable iff (!rst_b) core_irq |-> s_r.peripheral_group_irq_en && s_r.global_irq_en;
    endproperty
    a_core_gate: assert property (p_core_gate) else $error("core request without both enables"); // [R11]

    // [R9] Second flag view
    property p_flag_view2;
        @(posedge mclk) disable iff (!rst_b)
            (req.rd && req.addr == pie_pkg::ADDR_FLAG2) |=> rdata == $past(src_flags.f2);
    endproperty
    a_flag_view2: assert property (p_flag_view2) else $error("second flag view gated"); // [R9]

    // [R9] Third flag view
    property p_flag_view3;
        @(posedge mclk) disable iff (!rst_b)
            (req.rd && req.addr == pie_pkg::ADDR_FLAG3) |=> rdata == $past(src_flags.f3);
    endproperty
    a_flag_view3: assert property (p_flag_view3) else $error("third flag view gated"); // [R9]

    // [R9] Fourth flag view
    property p_flag_view4;
        @(posedge mclk) disable iff (!rst_b)
            (req.rd && req.addr == pie_pkg::ADDR_FLAG4) |=> rdata == $past(src_flags.f4);
    endproperty
    a_flag_view4: assert property (p_flag_view4) else $error("fourth flag view gated"); // [R9]

    // Request edges raise the sticky event bits; a clear in the same cycle loses
    sequence s_req_rise;
        !periph_req ##1 periph_req;
    endsequence
    sequence s_req_fall;
        periph_req ##1 !periph_req;
    endsequence
    property p_evt_rise;
        @(posedge mclk) disable iff (!rst_b) s_req_rise |=> s_r.evt_stat[pie_pkg::EVT_REQ_RISE];
    endproperty
    a_evt_rise: assert property (p_evt_rise) else $error("request rise not recorded");
    property p_evt_fall;
        @(posedge mclk) disable iff (!rst_b) s_req_fall |=> s_r.evt_stat[pie_pkg::EVT_REQ_FALL];
    endproperty
    a_evt_fall: assert property (p_evt_fall) else $error("request fall not recorded");

    sequence s_clr_rise_quiet;
        req.wr && req.addr == pie_pkg::ADDR_ISTAT && req.wdata[pie_pkg::EVT_REQ_RISE] &&
            (periph_req == s_r.core_req_q);
    endsequence
    property p_evt_clear;
        @(posedge mclk) disable iff (!rst_b) s_clr_rise_quiet |=> !s_r.evt_stat[pie_pkg::EVT_REQ_RISE];
    endproperty
    a_evt_clear: assert property (p_evt_clear) else $error("event bit not cleared by a one");

    sequence s_clr_rise_busy;
        req.wr && req.addr == pie_pkg::ADDR_ISTAT && req.wdata[pie_pkg::EVT_REQ_RISE] &&
            periph_req && !s_r.core_req_q;
    endsequence
    property p_evt_set_wins;
        @(posedge mclk) disable iff (!rst_b) s_clr_rise_busy |=> s_r.evt_stat[pie_pkg::EVT_REQ_RISE];
    endproperty
    a_evt_set_wins: assert property (p_evt_set_wins) else $error("clear beat a new event");

    // A zero mask keeps the event line quiet whatever the status holds
    property p_evt_masked;
        @(posedge mclk) disable iff (!rst_b) (s_r.evt_mask == 8'h00) |-> !evt_irq;
    endproperty
    a_evt_masked: assert property (p_evt_masked) else $error("event line high with zero mask");

    // Pending view shows the three request levels of the read cycle
    property p_pend_view;
        @(posedge mclk) disable iff (!rst_b)
            (req.rd && req.addr == pie_pkg::ADDR_PEND) |=>
                rdata == {5'h00, $past(core_irq), $past(periph_req), $past(any_req)};
    endproperty
    a_pend_view: assert property (p_pend_view) else $error("pending view wrong");

    // Indices above the map read zero
    property p_unmapped;
        @(posedge mclk) disable iff (!rst_b) (req.rd && req.addr > pie_pkg::ADDR_PEND) |=> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped index read nonzero");
endmodule // pie_bank

// ===== testbench/pie_testbench.sv
// Self-checking bench for the peripheral interrupt enable bank
`timescale 1ns/1ns
module testbench;
    logic                mclk;
    logic                rst_b;
    pie_pkg::pie_req_t   req;
    pie_pkg::pie_flags_t src_flags;
    logic [7:0]          rdata;
    logic                periph_req;
    logic                core_irq;
    logic                evt_irq;
    int                  failures;
    int                  cmp_count;
    logic [7:0]          masks [4];
    logic [7:0]          pats [4];
    logic [31:0]         all_mask;

    pie_bank u_dut (.mclk(mclk), .rst_b(rst_b), .req(req), .src_flags(src_flags), .rdata(rdata),
                    .periph_req(periph_req), .core_irq(core_irq), .evt_irq(evt_irq));

    // System clock, 8 ns period
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic check_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_pin(input string name, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One-cycle write strobe; the #1 lets the register update land before callers sample
    task automatic reg_write(input logic [3:0] addr, input logic [7:0] data);
        @(posedge mclk);
        req.addr  <= addr;
        req.wdata <= data;
        req.wr    <= 1'b1;
        @(posedge mclk);
        req.wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] addr, input logic [7:0] exp, input string name);
        @(posedge mclk);
        req.addr <= addr;
        req.rd   <= 1'b1;
        @(posedge mclk);
        req.rd <= 1'b0;
        #1;
        check_reg(name, exp, rdata);
    endtask

    task automatic set_flags(input logic [31:0] v);
        @(posedge mclk);
        src_flags <= v;
        #1;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        finish_test();
    end

    initial begin
        failures  = 0;
        cmp_count = 0;
        masks     = '{pie_pkg::MASK_EN1, pie_pkg::MASK_EN2, pie_pkg::MASK_EN3, pie_pkg::MASK_EN4};
        pats      = '{8'hFF, 8'h5A, 8'hA5, 8'h00};
        all_mask  = {masks[3], masks[2], masks[1], masks[0]};
        rst_b     = 1'b0;
        req       = '0;
        src_flags = '0;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        // Reset value, then patterns filtered by the implemented-bit masks
        for (int i = 0; i < 4; i++) begin
            reg_read(4'(i), pie_pkg::RESET_EN, "enable after reset");
            for (int p = 0; p < 4; p++) begin
                reg_write(4'(i), pats[p]);
                reg_read(4'(i), pats[p] & masks[i], "enable readback");
            end
        end
        // Flags show with every enable clear
        set_flags(32'hFFFF_FFFF);
        for (int i = 0; i < 4; i++) begin
            reg_read(pie_pkg::ADDR_FLAG1 + 4'(i), 8'hFF, "flag view");
        end
        // Read data fall back to zero one cycle after the answer
        @(posedge mclk);
        #1;
        check_pin("read data after one cycle", 1'b0, |rdata);
        // Group on but no source enabled
        reg_write(pie_pkg::ADDR_CTRL, 8'h40);
        check_pin("request, no enables", 1'b0, periph_req);
        reg_write(pie_pkg::ADDR_CTRL, 8'h00);
        for (int i = 0; i < 4; i++) begin
            reg_write(4'(i), 8'hFF);
        end
        check_pin("request, group off", 1'b0, periph_req);
        reg_write(pie_pkg::ADDR_CTRL, 8'h40);
        check_pin("request, group on", 1'b1, periph_req);
        check_pin("core, global off", 1'b0, core_irq);
        reg_write(pie_pkg::ADDR_CTRL, 8'hC0);
        check_pin("core, global on", 1'b1, core_irq);
        reg_read(pie_pkg::ADDR_CTRL, 8'hC0, "control readback");
        reg_read(pie_pkg::ADDR_PEND, 8'h07, "pending view");
        // Each source alone reaches the request only through an implemented enable
        for (int i = 0; i < 32; i++) begin
            set_flags(32'h0000_0001 << i);
            check_pin("single source", all_mask[i], periph_req);
        end
        reg_write(pie_pkg::ADDR_EN1, 8'h01);
        set_flags(32'h0000_0002);
        check_pin("disabled source", 1'b0, periph_req);
        // Event status: clear, unmask the rise event, then raise the request
        set_flags(32'h0000_0000);
        reg_write(pie_pkg::ADDR_ISTAT, 8'hFF);
        reg_write(pie_pkg::ADDR_IMASK, 8'h01);
        check_pin("event irq idle", 1'b0, evt_irq);
        set_flags(32'h0000_0001);
        reg_read(pie_pkg::ADDR_ISTAT, 8'h01, "event status rise");
        check_pin("event irq raised", 1'b1, evt_irq);
        reg_write(pie_pkg::ADDR_IMASK, 8'h00);
        check_pin("event irq masked", 1'b0, evt_irq);
        reg_write(pie_pkg::ADDR_IMASK, 8'h01);
        reg_write(pie_pkg::ADDR_ISTAT, 8'h01);
        check_pin("event irq cleared", 1'b0, evt_irq);
        reg_read(pie_pkg::ADDR_ISTAT, 8'h00, "event status cleared");
        // Falling request sets the other status bit, which the mask keeps off the line
        set_flags(32'h0000_0000);
        reg_read(pie_pkg::ADDR_ISTAT, 8'h02, "event status fall");
        check_pin("event irq fall masked", 1'b0, evt_irq);
        // Unmapped index ignores writes and reads zero
        reg_write(4'hC, 8'hFF);
        reg_read(4'hC, 8'h00, "unmapped read");
        // Flags stay high so the request check after reset means something
        set_flags(32'hFFFF_FFFF);
        // Reset in mid-run clears enables and control again
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        reg_read(pie_pkg::ADDR_EN1, 8'h00, "enable after second reset");
        reg_read(pie_pkg::ADDR_CTRL, 8'h00, "control after second reset");
        check_pin("request after second reset", 1'b0, periph_req);
        finish_test();
    end
endmodule // testbench
